// ### rtl/fscr_pkg.sv
// Package: register map, field positions, reset values and codes of the fault flag block
package fscr_pkg;
  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] SUPPLY_FAULT_FLAGS_IDX = 8'h0e;
  localparam logic [7:0] BOOST_FAULT_FLAGS_IDX = 8'h10;
  localparam logic [7:0] SUPPLY_FAULT_EN_IDX = 8'h14;
  localparam logic [7:0] BOOST_FAULT_EN_IDX = 8'h15;
  // Reset values
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [7:0] EN_RESET = 8'hff;
  // Two-bit enable field codes
  localparam logic [1:0] EN_WR_ON = 2'h3;
  localparam logic [1:0] EN_WR_OFF = 2'h1;
  localparam logic [1:0] EN_RD_ON = 2'h2;
  localparam logic [1:0] EN_RD_OFF = 2'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status bit positions, supply register; clear bit sits one below
  localparam int unsigned SUP_CHECKSUM_POS = 15;
  localparam int unsigned SUP_SYNC_POS = 13;
  localparam int unsigned SUP_PUMP_POS = 11;
  localparam int unsigned SUP_PUMP_CAP_POS = 9;
  localparam int unsigned SUP_IN_OC_POS = 7;
  localparam int unsigned SUP_LOGIC_UV_POS = 5;
  localparam int unsigned SUP_IN_OV_POS = 3;
  localparam int unsigned SUP_IN_UV_POS = 1;
  // Status bit positions, boost register
  localparam int unsigned BST_OVERHEAT_POS = 15;
  localparam int unsigned BST_ISET_SHORT_POS = 13;
  localparam int unsigned BST_STRING_RES_POS = 11;
  localparam int unsigned BST_MODE_RES_POS = 9;
  localparam int unsigned BST_FREQ_RES_POS = 7;
  localparam int unsigned BST_OC_POS = 5;
  localparam int unsigned BST_OV_HIGH_POS = 3;
  localparam int unsigned BST_OV_LOW_POS = 1;
  // Write channel states
  typedef enum logic [1:0] {
    FSCR_W_COLLECT = 2'b01,
    FSCR_W_RESP = 2'b10
  } fscr_wstate_t;
endpackage

// ### rtl/fscr_flag_bank.sv
// One bank of sticky fault flags with paired clear bits and two-bit enable fields
`timescale 1ns/10ps
`default_nettype none
module fscr_flag_bank #(
  parameter int unsigned N = 8,
  parameter logic [7:0] EN_RESET = fscr_pkg::EN_RESET
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] fault_i,
  input wire logic flag_wr,
  input wire logic [2*N-1:0] flag_wdata,
  input wire logic [2*N-1:0] flag_wmask,
  input wire logic en_wr,
  input wire logic [2*N-1:0] en_wdata,
  input wire logic [2*N-1:0] en_wmask,
  output logic [N-1:0] flags_o,
  output logic [2*N-1:0] flag_view,
  output logic [N-1:0] en_o,
  output logic [2*N-1:0] en_view,
  output logic pend_o
);
  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;
  logic [N-1:0] en_reg;
  logic [N-1:0] en_next;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pair
      logic clear_hit;
      logic [1:0] code;
      // (RL2) both bits in one write
      // (RL9) half pair leaves flag alone
      always_comb begin
        clear_hit = flag_wr && (&flag_wmask[2*i+1 -: 2]) && (&flag_wdata[2*i+1 -: 2]);
        code = en_wdata[2*i+1 -: 2];
        // (RL1) detection sets flag, set beats clear
        flag_next[i] = fault_i[i] | (flag_reg[i] & ~clear_hit);
        en_next[i] = en_reg[i];
        // (RL8) enable write encoding
        if (en_wr && (&en_wmask[2*i+1 -: 2])) begin
          if (code == fscr_pkg::EN_WR_ON) begin
            en_next[i] = 1'b1;
          end else if (code == fscr_pkg::EN_WR_OFF) begin
            en_next[i] = 1'b0;
          end
        end
      end
      // Clear bits always read back as zero
      assign flag_view[2*i+1 -: 2] = {flag_reg[i], 1'b0};
      assign en_view[2*i+1 -: 2] = en_reg[i] ? fscr_pkg::EN_RD_ON : fscr_pkg::EN_RD_OFF;
    end
  endgenerate

  // (RL3) flags reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= fscr_pkg::FLAGS_RESET[N-1:0];
      en_reg <= EN_RESET[N-1:0];
    end else begin
      flag_reg <= flag_next;
      en_reg <= en_next;
    end
  end

  assign flags_o = flag_reg;
  assign en_o = en_reg;
  assign pend_o = |(flag_reg & en_reg);
endmodule
`default_nettype wire

// ### rtl/fscr_top.sv
// Fault status and clear registers with an AXI4-Lite slave and an interrupt output
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (RL1) Flag reads 1 once its fault detected
// (RL2) Writing status and clear both 1 clears
// (RL3) Supply flags at 0Eh, reset to zero
// (RL4) Supply upper byte: checksum, sync, pump, cap
// (RL5) Supply lower byte: overcurrent, logic/input voltage
// (RL6) Boost flags at 10h, odd status bits
// (RL7) Boost pairs: heat, resistors, overcurrent, overvoltage
// (RL8) Enable fields read 2h/0h, write 3h/1h
// (RL9) Flags stick; half-pair writes change nothing
module fscr_top #(
  parameter logic [7:0] SUP_EN_RESET = fscr_pkg::EN_RESET,
  parameter logic [7:0] BST_EN_RESET = fscr_pkg::EN_RESET
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic checksum_error_in,
  input wire logic sync_missing_in,
  input wire logic pump_fault_in,
  input wire logic pump_cap_missing_in,
  input wire logic input_overcurrent_in,
  input wire logic logic_undervolt_in,
  input wire logic input_overvolt_in,
  input wire logic input_undervolt_in,
  input wire logic overheat_in,
  input wire logic current_resistor_short_in,
  input wire logic string_resistor_missing_in,
  input wire logic mode_resistor_missing_in,
  input wire logic freq_resistor_missing_in,
  input wire logic boost_overcurrent_in,
  input wire logic boost_overvolt_high_in,
  input wire logic boost_overvolt_low_in,
  output logic irq
);
  fscr_pkg::fscr_wstate_t wstate_reg, wstate_next;
  logic aw_held_reg, aw_held_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic arready_reg, arready_next;
  logic w_held_reg, w_held_next;
  logic [5:0] waddr_reg, waddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [1:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic irq_reg, irq_next;
  logic wr_commit;
  logic [15:0] wmask;
  logic [7:0] sup_fault, bst_fault;
  logic [7:0] sup_flags, bst_flags, sup_en, bst_en;
  logic [15:0] sup_view, bst_view, sup_en_view, bst_en_view;
  logic sup_pend, bst_pend;

  // (RL4) (RL5) supply pairs by status position
  // (RL7) boost pairs by status position
  always_comb begin
    sup_fault = 8'h00;
    bst_fault = 8'h00;
    sup_fault[fscr_pkg::SUP_CHECKSUM_POS / 2] = checksum_error_in;
    sup_fault[fscr_pkg::SUP_SYNC_POS / 2] = sync_missing_in;
    sup_fault[fscr_pkg::SUP_PUMP_POS / 2] = pump_fault_in;
    sup_fault[fscr_pkg::SUP_PUMP_CAP_POS / 2] = pump_cap_missing_in;
    sup_fault[fscr_pkg::SUP_IN_OC_POS / 2] = input_overcurrent_in;
    sup_fault[fscr_pkg::SUP_LOGIC_UV_POS / 2] = logic_undervolt_in;
    sup_fault[fscr_pkg::SUP_IN_OV_POS / 2] = input_overvolt_in;
    sup_fault[fscr_pkg::SUP_IN_UV_POS / 2] = input_undervolt_in;
    bst_fault[fscr_pkg::BST_OVERHEAT_POS / 2] = overheat_in;
    bst_fault[fscr_pkg::BST_ISET_SHORT_POS / 2] = current_resistor_short_in;
    bst_fault[fscr_pkg::BST_STRING_RES_POS / 2] = string_resistor_missing_in;
    bst_fault[fscr_pkg::BST_MODE_RES_POS / 2] = mode_resistor_missing_in;
    bst_fault[fscr_pkg::BST_FREQ_RES_POS / 2] = freq_resistor_missing_in;
    bst_fault[fscr_pkg::BST_OC_POS / 2] = boost_overcurrent_in;
    bst_fault[fscr_pkg::BST_OV_HIGH_POS / 2] = boost_overvolt_high_in;
    bst_fault[fscr_pkg::BST_OV_LOW_POS / 2] = boost_overvolt_low_in;
  end

  // Byte strobes gate whole lanes; upper lanes have no storage
  assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_commit = (wstate_reg == fscr_pkg::FSCR_W_COLLECT) && aw_held_reg && w_held_reg;

  // (RL3) (RL6) two banks, flags reset to zero
  fscr_flag_bank #(.N(8), .EN_RESET(SUP_EN_RESET)) u_supply (
    .aclk(aclk),
    .aresetn(aresetn),
    .fault_i(sup_fault),
    .flag_wr(wr_commit && waddr_reg == fscr_pkg::SUPPLY_FAULT_FLAGS_IDX[5:0]),
    .flag_wdata(wdata_reg),
    .flag_wmask(wmask),
    .en_wr(wr_commit && waddr_reg == fscr_pkg::SUPPLY_FAULT_EN_IDX[5:0]),
    .en_wdata(wdata_reg),
    .en_wmask(wmask),
    .flags_o(sup_flags),
    .flag_view(sup_view),
    .en_o(sup_en),
    .en_view(sup_en_view),
    .pend_o(sup_pend)
  );

  fscr_flag_bank #(.N(8), .EN_RESET(BST_EN_RESET)) u_boost (
    .aclk(aclk),
    .aresetn(aresetn),
    .fault_i(bst_fault),
    .flag_wr(wr_commit && waddr_reg == fscr_pkg::BOOST_FAULT_FLAGS_IDX[5:0]),
    .flag_wdata(wdata_reg),
    .flag_wmask(wmask),
    .en_wr(wr_commit && waddr_reg == fscr_pkg::BOOST_FAULT_EN_IDX[5:0]),
    .en_wdata(wdata_reg),
    .en_wmask(wmask),
    .flags_o(bst_flags),
    .flag_view(bst_view),
    .en_o(bst_en),
    .en_view(bst_en_view),
    .pend_o(bst_pend)
  );

  // Write channel: address and data captured in either order, one write in flight
  always_comb begin
    wstate_next = wstate_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    case (wstate_reg)
      fscr_pkg::FSCR_W_COLLECT: begin
        if (s_axi_awvalid && !aw_held_reg) begin
          aw_held_next = 1'b1;
          waddr_next = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && !w_held_reg) begin
          w_held_next = 1'b1;
          wdata_next = s_axi_wdata[15:0];
          wstrb_next = s_axi_wstrb[1:0];
        end
        if (wr_commit) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          bvalid_next = 1'b1;
          bresp_next = fscr_pkg::RESP_SLVERR;
          if (waddr_reg == fscr_pkg::SUPPLY_FAULT_FLAGS_IDX[5:0] ||
              waddr_reg == fscr_pkg::BOOST_FAULT_FLAGS_IDX[5:0] ||
              waddr_reg == fscr_pkg::SUPPLY_FAULT_EN_IDX[5:0] ||
              waddr_reg == fscr_pkg::BOOST_FAULT_EN_IDX[5:0]) begin
            bresp_next = fscr_pkg::RESP_OKAY;
          end
          wstate_next = fscr_pkg::FSCR_W_RESP;
        end
      end
      fscr_pkg::FSCR_W_RESP: begin
        if (s_axi_bready) begin
          bvalid_next = 1'b0;
          wstate_next = fscr_pkg::FSCR_W_COLLECT;
        end
      end
      default: begin
        wstate_next = fscr_pkg::FSCR_W_COLLECT;
        bvalid_next = 1'b0;
      end
    endcase
    // Readies come from registers so that no bus output is combinational
    awready_next = (wstate_next == fscr_pkg::FSCR_W_COLLECT) && !aw_held_next;
    wready_next = (wstate_next == fscr_pkg::FSCR_W_COLLECT) && !w_held_next;
  end

  // Read channel: one-cycle answer, reads have no side effect on flags
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = fscr_pkg::RESP_OKAY;
      case (s_axi_araddr[7:2])
        fscr_pkg::SUPPLY_FAULT_FLAGS_IDX[5:0]: rdata_next = {16'h0000, sup_view};
        fscr_pkg::BOOST_FAULT_FLAGS_IDX[5:0]: rdata_next = {16'h0000, bst_view};
        fscr_pkg::SUPPLY_FAULT_EN_IDX[5:0]: rdata_next = {16'h0000, sup_en_view};
        fscr_pkg::BOOST_FAULT_EN_IDX[5:0]: rdata_next = {16'h0000, bst_en_view};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = fscr_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // (RL2) pin follows enabled pending flags
  always_comb begin
    irq_next = sup_pend | bst_pend;
  end

  // Register stage for all bus and interrupt state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_reg <= fscr_pkg::FSCR_W_COLLECT;
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      arready_reg <= 1'b1;
      w_held_reg <= 1'b0;
      waddr_reg <= 6'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      wstate_reg <= wstate_next;
      aw_held_reg <= aw_held_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      irq_reg <= irq_next;
    end
  end

  // Every bus output comes straight from its register
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq = irq_reg;

  // Checks on flag behaviour and bus answers
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic sup_wr;
  assign sup_wr = wr_commit && waddr_reg == fscr_pkg::SUPPLY_FAULT_FLAGS_IDX[5:0];

  AST_RESET_ZERO: assert property ($rose(aresetn) |-> sup_flags == 8'h00 // (RL3)
    && bst_flags == 8'h00)
    else $error("flags not zero after reset");
  AST_DETECT_SETS: assert property (input_undervolt_in |=> sup_flags[0]) // (RL1)
    else $error("fault did not set its flag");
  AST_PAIR_CLEAR: assert property (sup_wr && wstrb_reg[0] && wdata_reg[1:0] == 2'b11 // (RL2)
    && !input_undervolt_in |=> !sup_flags[0])
    else $error("paired write did not clear flag");
  AST_STICKY: assert property (sup_flags[0] // (RL9)
    && !(sup_wr && wstrb_reg[0] && wdata_reg[1:0] == 2'b11) |=> sup_flags[0])
    else $error("flag dropped without paired clear");
  AST_HALF_PAIR: assert property (sup_wr && wstrb_reg[0] && ^wdata_reg[1:0] // (RL9)
    && sup_flags[0] |=> sup_flags[0])
    else $error("half-pair write changed flag");
  AST_CHECKSUM_POS: assert property (s_axi_arvalid && s_axi_arready // (RL4)
    && s_axi_araddr[7:2] == fscr_pkg::SUPPLY_FAULT_FLAGS_IDX[5:0]
    |=> s_axi_rdata[31:14] == {16'h0000, $past(sup_flags[7]), 1'b0})
    else $error("checksum flag not at bit 15");
  AST_OVERHEAT_POS: assert property (s_axi_arvalid && s_axi_arready // (RL6)
    && s_axi_araddr[7:2] == fscr_pkg::BOOST_FAULT_FLAGS_IDX[5:0]
    |=> s_axi_rdata[15:0] == {$past(bst_flags[7]), 1'b0, $past(bst_flags[6]), 1'b0,
    $past(bst_flags[5]), 1'b0, $past(bst_flags[4]), 1'b0, $past(bst_flags[3]), 1'b0,
    $past(bst_flags[2]), 1'b0, $past(bst_flags[1]), 1'b0, $past(bst_flags[0]), 1'b0})
    else $error("boost layout wrong");
  AST_BOOST_MAP: assert property (overheat_in |=> bst_flags[7]) // (RL7)
    else $error("overheat flag not set");
  AST_LOW_BYTE: assert property (input_overcurrent_in |=> sup_flags[3]) // (RL5)
    else $error("overcurrent flag not set");
  AST_EN_CODE: assert property (wr_commit && wstrb_reg[0] // (RL8)
    && waddr_reg == fscr_pkg::SUPPLY_FAULT_EN_IDX[5:0]
    && wdata_reg[1:0] == fscr_pkg::EN_WR_OFF |=> !sup_en[0])
    else $error("enable write code ignored");
  AST_IRQ: assert property (sup_flags[0] && sup_en[0] |=> irq) // (RL2)
    else $error("interrupt missing for pending flag");
  AST_IRQ_LOW: assert property ((sup_flags & sup_en) == 8'h00 // (RL2)
    && (bst_flags & bst_en) == 8'h00 |=> !irq)
    else $error("interrupt high with nothing pending");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  COV_PAIR_CLEAR: cover property (sup_flags[0] ##1 sup_wr ##1 !sup_flags[0]);
  COV_IRQ: cover property ($rose(irq));
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == fscr_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

// ### tb/tb_fault_status_clear_regs.sv
// Self-checking bench for the fault flag registers over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module tb_fault_status_clear_regs;
  localparam logic [7:0] SUP_A = 8'(fscr_pkg::SUPPLY_FAULT_FLAGS_IDX << 2);
  localparam logic [7:0] BST_A = 8'(fscr_pkg::BOOST_FAULT_FLAGS_IDX << 2);
  localparam logic [7:0] SEN_A = 8'(fscr_pkg::SUPPLY_FAULT_EN_IDX << 2);
  localparam logic [7:0] BEN_A = 8'(fscr_pkg::BOOST_FAULT_EN_IDX << 2);
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] fault;
  int mismatches, checks;

  fscr_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .checksum_error_in(fault[7]), .sync_missing_in(fault[6]), .pump_fault_in(fault[5]),
    .pump_cap_missing_in(fault[4]), .input_overcurrent_in(fault[3]),
    .logic_undervolt_in(fault[2]), .input_overvolt_in(fault[1]),
    .input_undervolt_in(fault[0]), .overheat_in(fault[15]),
    .current_resistor_short_in(fault[14]), .string_resistor_missing_in(fault[13]),
    .mode_resistor_missing_in(fault[12]), .freq_resistor_missing_in(fault[11]),
    .boost_overcurrent_in(fault[10]), .boost_overvolt_high_in(fault[9]),
    .boost_overvolt_low_in(fault[8]), .irq(irq));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data offered together; each released at its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    // Response accepted a cycle late so the held response is exercised
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write resp", {30'h0, fscr_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, exp, d);
    chk({what, " resp"}, {30'h0, fscr_pkg::RESP_OKAY}, {30'h0, r});
  endtask

  // One-cycle fault pulse, then time for flag and interrupt to settle
  task automatic pulse(input int i);
    @(posedge aclk);
    fault <= 16'h0001 << i;
    @(posedge aclk);
    fault <= 16'h0000;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_reset();
    rd_chk("supply flags rst", SUP_A, 32'h0);
    rd_chk("boost flags rst", BST_A, 32'h0);
    rd_chk("supply en rst", SEN_A, 32'h0000aaaa);
    rd_chk("boost en rst", BEN_A, 32'h0000aaaa);
    chk("irq rst", 32'h0, {31'h0, irq});
  endtask

  // Every fault: position, stickiness, half-pair writes, paired clear
  task automatic t_map();
    logic [7:0] a;
    logic [15:0] m;
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? SUP_A : BST_A;
      m = 16'h0002 << (2 * (i % 8));
      pulse(i);
      rd_chk("flag set", a, {16'h0000, m});
      chk("irq set", 32'h1, {31'h0, irq});
      wr(a, m);
      rd_chk("status only write", a, {16'h0000, m});
      wr(a, m >> 1);
      rd_chk("ack only write", a, {16'h0000, m});
      wr(a, m | (m >> 1));
      rd_chk("paired clear", a, 32'h0);
      chk("irq after clear", 32'h0, {31'h0, irq});
    end
  endtask

  // Enable field codes: off, hold, on
  task automatic t_enable();
    wr(SEN_A, 16'h5555);
    rd_chk("supply en off", SEN_A, 32'h0);
    wr(SEN_A, 16'hffff);
    rd_chk("supply en on", SEN_A, 32'h0000aaaa);
    wr(BEN_A, 16'h0001);
    rd_chk("boost en off", BEN_A, 32'h0000aaa8);
    pulse(8);
    rd_chk("masked flag", BST_A, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(BEN_A, 16'h0000);
    rd_chk("boost en hold", BEN_A, 32'h0000aaa8);
    wr(BEN_A, 16'h0003);
    rd_chk("boost en on", BEN_A, 32'h0000aaaa);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(BST_A, 16'h0003);
    rd_chk("masked cleared", BST_A, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(8'h20, 16'hffff, r);
    chk("unmapped bresp", {30'h0, fscr_pkg::RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h20, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", {30'h0, fscr_pkg::RESP_SLVERR}, {30'h0, r});
  endtask

  // A reset in mid-run drops a recorded fault and the interrupt
  task automatic t_rst_mid();
    pulse(7);
    rd_chk("flag before rst", SUP_A, 32'h00008000);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("flag after rst", SUP_A, 32'h0);
    chk("irq after rst", 32'h0, {31'h0, irq});
  endtask

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_sim();
  end

  initial begin
    mismatches = 0;
    checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    fault = 16'h0000;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_map();
    t_enable();
    t_unmapped();
    t_rst_mid();
    end_sim();
  end
endmodule
`default_nettype wire
